// [fia_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: two priority bits give level zero to three
// RULE2: in service, only strictly higher levels preempt
// RULE3: level three service is never preempted
// RULE4: higher level wins among pending requests
// RULE5: fixed ranking breaks ties within one level
// RULE6: winner selects its fixed vector address
// RULE7: each source gated by its enable bit
// RULE8: priority bits mirror enable bit positions
// RULE9: power-down wake only from permitted sources
// RULE10: external pins sampled in third phase
// RULE11: timer flags set third phase, polled later
// RULE12: vector call lasts four machine cycles
// RULE13: call only in instruction's last machine cycle
// RULE14: worst single-interrupt response twelve machine cycles
// RULE15: machine cycle is four clocks
// RULE16: enabled external interrupt wakes idle or power-down
// RULE17: global enable masks every source
// RULE18: vectoring clears timer and edge flags
// RULE19: only return-from-interrupt ends active level
// RULE20: no call on register write or return
// RULE21: reset clears enables, priorities, in-service state
// RULE22: in-service levels nest four deep
module fia_arbiter
    import fia_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              ce,          // low freezes all state
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    input  wire logic              external_pin_0,
    input  wire logic              external_pin_1,
    input  wire logic [7:0]        src_set,     // flag set pulses, rank order
    input  wire fia_pkg::fia_core_t core_in,
    output fia_pkg::fia_call_t     call_out,
    output logic [1:0]             mc_phase,    // clock within machine cycle
    output logic                   wake
);
    import fia_pkg::*;

    logic [1:0]  phase_r, phase_nxt;          // machine cycle phase
    logic [7:0]  men_r, men_nxt;              // main_enable_register
    logic [7:0]  xen_r, xen_nxt;              // extended_enable_register
    logic [7:0]  plo_a_r, plo_a_nxt;
    logic [7:0]  phi_a_r, phi_a_nxt;
    logic [7:0]  plo_b_r, plo_b_nxt;
    logic [7:0]  phi_b_r, phi_b_nxt;
    logic [7:0]  ctrl_r, ctrl_nxt;            // edge mode per pin
    logic [7:0]  flag_r, flag_nxt;            // request flags
    logic [7:0]  catch_r, catch_nxt;          // events awaiting third phase
    logic [7:0]  snap_r, snap_nxt;            // flags seen by next poll
    logic [1:0]  pin_q_r, pin_q_nxt;          // last pin samples
    logic        wr_pend_r, wr_pend_nxt;      // write data phase due
    logic [7:0]  wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [2:0]  busy_r, busy_nxt;            // call in progress, in MCs
    logic [2:0]  hold_r, hold_nxt;            // register access, in MCs
    fia_call_t   call_r, call_nxt;
    logic [15:0] last_vec_r, last_vec_nxt;
    logic        wake_r, wake_nxt;

    logic        c3, mc_end, poll, acc, fire, prio_wr, sw_flag_wr, accept;
    logic [7:0]  en_vec, req, clr_mask, pend_en, wake_src;
    logic [15:0] lvl_vec;
    logic        win_hit;
    logic [2:0]  win_idx;
    logic [1:0]  win_level, top_level;
    logic        stk_empty;
    logic [2:0]  stk_depth;

    assign c3     = (phase_r == PH_C3);                         // RULE10
    assign mc_end = (phase_r == PH_LAST);                       // RULE15
    assign poll   = (phase_r == PH_POLL);
    assign acc    = hsel && hready && htrans[1];

    // per-source enable and level vectors
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            en_vec[i]        = src_enable(i, men_r, xen_r);     // RULE7
            lvl_vec[2*i +: 2] = src_level(i, plo_a_r, phi_a_r,
                                          plo_b_r, phi_b_r);   // RULE1 RULE8
        end
    end

    // global enable overrides everything
    assign req     = snap_r & en_vec & {8{men_r[GLB_BIT]}};    // RULE17
    assign pend_en = flag_r & en_vec & {8{men_r[GLB_BIT]}};

    fia_resolve #(.N(NSRC)) u_resolve (
        .req   (req),
        .lvl   (lvl_vec),
        .hit   (win_hit),
        .idx   (win_idx),
        .level (win_level)
    );

    fia_level_stack #(.DEPTH(STACK_DEPTH)) u_stack (
        .clock      (clock),
        .rst        (rst),
        .ce         (ce),
        .push       (fire),
        .push_level (win_level),
        .pop        (core_in.return_from_interrupt),                             // RULE19
        .top_level  (top_level),
        .empty      (stk_empty),
        .depth      (stk_depth)
    );

    // strictly higher only; nothing beats level three
    assign accept = win_hit                                     // RULE4 RULE5
                 && (stk_empty || win_level > top_level); // RULE2 RULE3

    // write to enable, priority or flag registers in this data phase
    assign prio_wr    = wr_pend_r && (wr_addr_r <= A_PHI_B);
    assign sw_flag_wr = wr_pend_r && (wr_addr_r == A_FLAGS);

    // call only at a quiet last machine cycle
    assign fire = poll && accept && core_in.last_cycle              // RULE13
               && !core_in.blocked_instr && !core_in.return_from_interrupt           // RULE20
               && !prio_wr && hold_r == 3'h0 && busy_r == 3'h0;     // RULE12 RULE14

    // flags cleared by vectoring: timers always, externals in edge mode
    assign clr_mask = fire ? ((8'h01 << win_idx) & (TIMER_MASK
                      | ({2'h0, ctrl_r[CTRL_EDGE1], 5'h00})
                      | ({7'h00, ctrl_r[CTRL_EDGE0]}))) : 8'h00; // RULE18

    // bus slave: zero wait, read data registered from address phase
    always_comb begin
        wr_pend_nxt = acc && hwrite;
        wr_addr_nxt = acc ? haddr[7:0] : wr_addr_r;
        hrdata_nxt  = hrdata_r;
        if (acc && !hwrite) begin
            case (haddr[7:0])
                A_MAIN_EN: hrdata_nxt = {24'h0, men_r};
                A_EXT_EN:  hrdata_nxt = {24'h0, xen_r};
                A_PLO_A:   hrdata_nxt = {24'h0, plo_a_r};
                A_PHI_A:   hrdata_nxt = {24'h0, phi_a_r};
                A_PLO_B:   hrdata_nxt = {24'h0, plo_b_r};
                A_PHI_B:   hrdata_nxt = {24'h0, phi_b_r};
                A_FLAGS:   hrdata_nxt = {24'h0, flag_r};
                A_CTRL:    hrdata_nxt = {24'h0, ctrl_r};
                A_STATUS:  hrdata_nxt = {last_vec_r, 9'h0, stk_depth,
                                         stk_empty, 1'b0, top_level};
                default:   hrdata_nxt = 32'h0;   // unmapped reads zero
            endcase
        end
    end

    // register file writes from the data phase
    always_comb begin
        men_nxt   = men_r;
        xen_nxt   = xen_r;
        plo_a_nxt = plo_a_r;
        phi_a_nxt = phi_a_r;
        plo_b_nxt = plo_b_r;
        phi_b_nxt = phi_b_r;
        ctrl_nxt  = ctrl_r;
        if (wr_pend_r) begin
            case (wr_addr_r)
                A_MAIN_EN: men_nxt   = hwdata[7:0];
                A_EXT_EN:  xen_nxt   = hwdata[7:0];
                A_PLO_A:   plo_a_nxt = hwdata[7:0];
                A_PHI_A:   phi_a_nxt = hwdata[7:0];
                A_PLO_B:   plo_b_nxt = hwdata[7:0];
                A_PHI_B:   phi_b_nxt = hwdata[7:0];
                A_CTRL:    ctrl_nxt  = hwdata[7:0];
                default:   ;             // flags handled below, rest ignored
            endcase
        end
    end

    // flag group: software write, vector clear, then hardware sets win
    always_comb begin
        flag_nxt  = flag_r;
        catch_nxt = catch_r | (src_set & ~EXT_MASK);
        pin_q_nxt = pin_q_r;
        snap_nxt  = snap_r;
        if (sw_flag_wr) begin
            flag_nxt = hwdata[7:0];
        end
        flag_nxt = flag_nxt & ~clr_mask;                            // RULE18
        if (c3) begin
            // events gathered since last third phase land now
            flag_nxt  = flag_nxt | catch_r | (src_set & ~EXT_MASK); // RULE11
            catch_nxt = 8'h00;
            pin_q_nxt = {external_pin_1, external_pin_0};
            if (ctrl_r[CTRL_EDGE0]) begin
                flag_nxt[S_EXT0] = flag_nxt[S_EXT0]
                                 | (pin_q_r[0] & ~external_pin_0); // RULE10
            end else begin
                flag_nxt[S_EXT0] = ~external_pin_0;                // RULE10
            end
            if (ctrl_r[CTRL_EDGE1]) begin
                flag_nxt[S_EXT1] = flag_nxt[S_EXT1]
                                 | (pin_q_r[1] & ~external_pin_1);
            end else begin
                flag_nxt[S_EXT1] = ~external_pin_1;
            end
        end
        // snapshot at cycle end: a flag set this cycle polls next cycle
        if (mc_end) begin
            snap_nxt = flag_nxt;                                    // RULE11
        end
    end

    // arbitration group: phase, call timing, wake
    always_comb begin
        phase_nxt    = phase_r + 2'h1;                              // RULE15
        busy_nxt     = busy_r;
        hold_nxt     = hold_r;
        call_nxt     = call_r;
        call_nxt.req = 1'b0;
        last_vec_nxt = last_vec_r;
        if (mc_end && busy_r != 3'h0) begin
            busy_nxt = busy_r - 3'h1;
        end
        if (mc_end && hold_r != 3'h0) begin
            hold_nxt = hold_r - 3'h1;
        end
        if (prio_wr) begin
            hold_nxt = WR_HOLD_MC;                                  // RULE14
        end
        if (fire) begin
            call_nxt     = '{req: 1'b1, level: win_level,
                             vector: VEC[win_idx]};                 // RULE6
            last_vec_nxt = VEC[win_idx];
            busy_nxt     = CALL_MC;                                 // RULE12
        end
        // in power-down, rc-clocked watchdog and converter may wake; timers never
        wake_src = PD_WAKE | (core_in.rc_clock ? RC_WAKE : 8'h00); // RULE9
        if (core_in.powerdown) begin
            wake_nxt = |(pend_en & wake_src);                       // RULE16
        end else if (core_in.idle) begin
            wake_nxt = |pend_en;                                    // RULE16
        end else begin
            wake_nxt = 1'b0;
        end
    end

    // all state registers; reset clears every enable and priority
    always_ff @(posedge clock) begin
        if (rst) begin
            phase_r    <= 2'h0;
            men_r      <= RST_REG;                                  // RULE21
            xen_r      <= RST_REG;
            plo_a_r    <= RST_REG;
            phi_a_r    <= RST_REG;
            plo_b_r    <= RST_REG;
            phi_b_r    <= RST_REG;
            ctrl_r     <= RST_REG;
            flag_r     <= 8'h00;
            catch_r    <= 8'h00;
            snap_r     <= 8'h00;
            pin_q_r    <= 2'h3;
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 8'h00;
            hrdata_r   <= 32'h0;
            busy_r     <= 3'h0;
            hold_r     <= 3'h0;
            call_r     <= '0;
            last_vec_r <= 16'h0;
            wake_r     <= 1'b0;
        end else if (ce) begin
            phase_r    <= phase_nxt;
            men_r      <= men_nxt;
            xen_r      <= xen_nxt;
            plo_a_r    <= plo_a_nxt;
            phi_a_r    <= phi_a_nxt;
            plo_b_r    <= plo_b_nxt;
            phi_b_r    <= phi_b_nxt;
            ctrl_r     <= ctrl_nxt;
            flag_r     <= flag_nxt;
            catch_r    <= catch_nxt;
            snap_r     <= snap_nxt;
            pin_q_r    <= pin_q_nxt;
            wr_pend_r  <= wr_pend_nxt;
            wr_addr_r  <= wr_addr_nxt;
            hrdata_r   <= hrdata_nxt;
            busy_r     <= busy_nxt;
            hold_r     <= hold_nxt;
            call_r     <= call_nxt;
            last_vec_r <= last_vec_nxt;
            wake_r     <= wake_nxt;
        end
    end

    assign hreadyout = 1'b1;   // never stretches a transfer
    assign hresp     = 1'b0;   // always okay
    assign hrdata    = hrdata_r;
    assign call_out  = call_r;
    assign mc_phase  = phase_r;
    assign wake      = wake_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_strictly_higher;
        call_out.req |-> $past(stk_empty) || call_out.level > $past(top_level);
    endproperty
    a_strictly_higher: assert property (p_strictly_higher) // RULE2
        else $error("call did not outrank active level");

    property p_top_level_locked;
        call_out.req |-> !(!$past(stk_empty) && $past(top_level) == 2'h3);
    endproperty
    a_top_level_locked: assert property (p_top_level_locked) // RULE3
        else $error("level three service was preempted");

    property p_vector_match;
        call_out.req |-> call_out.vector == VEC[$past(win_idx)];
    endproperty
    a_vector_match: assert property (p_vector_match) // RULE6
        else $error("vector does not match winner");

    sequence s_quiet_call;
        !call_out.req [*8] ##1 !call_out.req [*7];
    endsequence
    property p_call_spacing;
        call_out.req |=> s_quiet_call;
    endproperty
    a_call_spacing: assert property (p_call_spacing) // RULE12
        else $error("second call inside four machine cycles");

    property p_last_cycle;
        call_out.req |-> $past(core_in.last_cycle) && $past(poll);
    endproperty
    a_last_cycle: assert property (p_last_cycle) // RULE13
        else $error("call outside last machine cycle poll");

    property p_blocked;
        call_out.req |-> !$past(core_in.return_from_interrupt) && !$past(core_in.blocked_instr);
    endproperty
    a_blocked: assert property (p_blocked) // RULE20
        else $error("call during blocked instruction");

    property p_auto_clear;
        (call_out.req && $past(clr_mask) != 8'h00 && !$past(c3))
            |-> (flag_r & $past(clr_mask)) == 8'h00;
    endproperty
    a_auto_clear: assert property (p_auto_clear) // RULE18
        else $error("vectored flag not cleared");

    property p_reset_clear;
        $past(rst) |-> men_r == RST_REG && phi_a_r == RST_REG && stk_empty;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // RULE21
        else $error("reset left enables or stack set");

    property p_level_pin;
        (ce && c3 && !ctrl_r[CTRL_EDGE0])
            |=> flag_r[S_EXT0] == !$past(external_pin_0);
    endproperty
    a_level_pin: assert property (p_level_pin) // RULE10
        else $error("level mode flag does not follow pin");
endmodule
`default_nettype wire

// [fia_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// core sequencer stand-in: runs vector calls, returns on request
module fia_core_model
    import fia_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               return_from_interrupt_cmd, // bench asks for a return
    input  wire logic [2:0]         pm_in,    // idle, powerdown, rc clock
    input  wire fia_pkg::fia_call_t call_in,
    output fia_pkg::fia_core_t      core_out
);
    logic [4:0] busy_r;   // clocks left in the running call
    logic [4:0] busy_nxt;
    // a call holds the core for four machine cycles
    always_comb begin
        busy_nxt = busy_r;
        if (call_in.req) begin
            busy_nxt = 5'h10;
        end else if (busy_r != 5'h0) begin
            busy_nxt = busy_r - 5'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_r <= 5'h0;
        end else begin
            busy_r <= busy_nxt;
        end
    end
    // one-cycle instructions when free, so every poll is a last cycle
    assign core_out = {busy_r == 5'h0, 1'b0, return_from_interrupt_cmd, pm_in};
endmodule
`default_nettype wire

// [fia_level_stack.sv]
`timescale 1ns/1ps
`default_nettype none
// nested in-service levels; levels only rise, so depth 4 suffices
module fia_level_stack #(
    parameter int DEPTH = 4
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       push,
    input  wire logic [1:0] push_level,
    input  wire logic       pop,
    output logic [1:0]      top_level,
    output logic            empty,
    output logic [2:0]      depth
);
    logic [1:0] lv_r   [DEPTH];   // entries, 0 at bottom
    logic [1:0] lv_nxt [DEPTH];
    logic [2:0] cnt_r;            // entries in use
    logic [2:0] cnt_nxt;

    // push and pop together replace the top entry
    always_comb begin
        lv_nxt  = lv_r;
        cnt_nxt = cnt_r;
        if (pop && cnt_r != 3'h0) begin
            cnt_nxt = cnt_r - 3'h1;
        end
        if (push && cnt_nxt < 3'(DEPTH)) begin
            lv_nxt[cnt_nxt[1:0]] = push_level; // RULE22
            cnt_nxt              = cnt_nxt + 3'h1;
        end
    end

    // registers only; ce freezes
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r <= 3'h0;
            for (int i = 0; i < DEPTH; i++) begin
                lv_r[i] <= 2'h0;
            end
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            lv_r  <= lv_nxt;
        end
    end

    assign empty     = (cnt_r == 3'h0);
    assign depth     = cnt_r;
    assign top_level = empty ? 2'h0 : lv_r[2'(cnt_r - 3'h1)];
endmodule
`default_nettype wire

// [fia_pkg.sv]
`default_nettype none
package fia_pkg;
    // sources by arbitration rank, index 0 wins ties
    localparam int NSRC   = 8;
    localparam int S_EXT0 = 0;
    localparam int S_BO   = 1;
    localparam int S_WD   = 2;
    localparam int S_T0   = 3;
    localparam int S_CONV = 4;
    localparam int S_EXT1 = 5;
    localparam int S_KB   = 6;
    localparam int S_T1   = 7;

    // machine cycle timing in clocks or machine cycles, then stack depth
    localparam int         CLK_PER_MC  = 4;
    localparam logic [1:0] PH_POLL     = 2'h0;  // first phase
    localparam logic [1:0] PH_C3       = 2'h2;  // third_clock_phase
    localparam logic [1:0] PH_LAST     = 2'h3;
    localparam logic [2:0] CALL_MC     = 3'h4;  // vector call length
    localparam logic [2:0] WR_HOLD_MC  = 3'h2;  // enable/priority access
    localparam int         MAX_LAT_MC  = 12;
    localparam int         MAX_LAT_CLK = MAX_LAT_MC * CLK_PER_MC;
    localparam int         STACK_DEPTH = 4;

    // register byte offsets
    localparam logic [7:0] A_MAIN_EN = 8'h00; // main_enable_register
    localparam logic [7:0] A_EXT_EN  = 8'h04; // extended_enable_register
    localparam logic [7:0] A_PLO_A   = 8'h08; // priority_low_bits_a
    localparam logic [7:0] A_PHI_A   = 8'h0c; // priority_high_bits_a
    localparam logic [7:0] A_PLO_B   = 8'h10; // priority_low_bits_b
    localparam logic [7:0] A_PHI_B   = 8'h14; // priority_high_bits_b
    localparam logic [7:0] A_FLAGS   = 8'h18; // request flags, rank order
    localparam logic [7:0] A_CTRL    = 8'h1c; // external edge modes
    localparam logic [7:0] A_STATUS  = 8'h20; // in-service state

    // field positions and reset values
    localparam int         GLB_BIT     = 7;     // global_irq_enable
    localparam int         CTRL_EDGE0  = 0;
    localparam int         CTRL_EDGE1  = 1;
    localparam logic [7:0] RST_REG     = 8'h00;
    localparam logic [7:0] EXT_MASK    = 8'h21; // both external flags
    localparam logic [7:0] TIMER_MASK  = 8'h88;
    localparam logic [7:0] PD_WAKE     = 8'h63; // ext0, bo, ext1, keypad
    localparam logic [7:0] RC_WAKE     = 8'h14; // watchdog, converter
    localparam logic [7:0] IN_B_REG    = 8'h44; // watchdog, keypad

    // bit of each source within its enable/priority register
    localparam int SRC_BIT [NSRC] = '{0, 5, 4, 1, 6, 2, 1, 3};
    localparam logic [15:0] VEC [NSRC] = '{16'h0003, 16'h002b, 16'h0053,
        16'h000b, 16'h005b, 16'h0013, 16'h003b, 16'h001b};

    // core sequencer status, sampled at each poll
    typedef struct packed {
        logic last_cycle;    // last machine cycle of instruction
        logic blocked_instr; // writes enable/priority register
        logic return_from_interrupt;          // return_from_interrupt executing
        logic idle;
        logic powerdown;
        logic rc_clock;      // core runs from internal rc
    } fia_core_t;

    // hardware_vector_call request to the core
    typedef struct packed {
        logic        req;
        logic [1:0]  level;
        logic [15:0] vector;
    } fia_call_t;

    // enable bit of source idx
    function automatic logic src_enable(input int idx,
        input logic [7:0] en_a, input logic [7:0] en_b);
        return IN_B_REG[idx] ? en_b[SRC_BIT[idx]] : en_a[SRC_BIT[idx]];
    endfunction

    // level of source idx, high bit then low bit
    function automatic logic [1:0] src_level(input int idx,
        input logic [7:0] lo_a, input logic [7:0] hi_a,
        input logic [7:0] lo_b, input logic [7:0] hi_b);
        logic [1:0] lv;
        lv = IN_B_REG[idx] ? {hi_b[SRC_BIT[idx]], lo_b[SRC_BIT[idx]]}
                           : {hi_a[SRC_BIT[idx]], lo_a[SRC_BIT[idx]]};
        return lv;
    endfunction
endpackage
`default_nettype wire

// [fia_resolve.sv]
`timescale 1ns/1ps
`default_nettype none
// picks the highest level, then the lowest rank index
module fia_resolve #(
    parameter int N = 8
) (
    input  wire logic [N-1:0]   req,   // enabled requests
    input  wire logic [2*N-1:0] lvl,   // two level bits per source
    output logic                hit,
    output logic [2:0]          idx,
    output logic [1:0]          level
);
    // scan levels downward, ranks upward; first match sticks
    always_comb begin
        hit   = 1'b0;
        idx   = 3'h0;
        level = 2'h0;
        for (int l = 3; l >= 0; l--) begin
            for (int i = 0; i < N; i++) begin
                if (!hit && req[i] && lvl[2*i +: 2] == 2'(l)) begin
                    hit   = 1'b1;
                    idx   = 3'(i);
                    level = 2'(l);
                end
            end
        end
    end
endmodule
`default_nettype wire

// [four_level_interrupt_arbiter_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
 $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module four_level_interrupt_arbiter_test
    import fia_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, wake;
    logic        p0 = 1'b1, p1 = 1'b1, return_from_interrupt_cmd = 1'b0;
    logic [2:0]  pm = 3'h0;  // core idle, powerdown, rc clock
    logic [1:0]  htrans = 2'h0, mc_phase;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [7:0]  src_set = 8'h0;
    logic [7:0]  rg [6];  // model copy of enable and priority registers
    fia_core_t   core;
    fia_call_t   call;
    int          error_cnt = 0, checks = 0;
    localparam int EB [8] = '{0, 5, 4, 1, 6, 2, 1, 3}; // bit per source
    localparam logic [7:0] MSK [6] = '{8'hef, 8'h12, 8'h6f, 8'h6f, 8'h12,
        8'h12};
    localparam logic [15:0] VT [8] = '{16'h0003, 16'h002b, 16'h0053,
        16'h000b, 16'h005b, 16'h0013, 16'h003b, 16'h001b};
    always #20 clock = ~clock;
    fia_arbiter u_fia_arbiter (.clock(clock), .rst(rst), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .external_pin_0(p0), .external_pin_1(p1), .src_set(src_set),
        .core_in(core), .call_out(call), .mc_phase(mc_phase), .wake(wake));
    fia_core_model u_fia_core_model (.clock(clock), .rst(rst),
        .return_from_interrupt_cmd(return_from_interrupt_cmd), .pm_in(pm), .call_in(call), .core_out(core));
    // watchdog and keypad live in the second register pair
    function automatic logic en(input int i);
        logic [7:0] e;
        e = (i == 2 || i == 6) ? rg[1] : rg[0];
        return e[EB[i]] & rg[0][7];
    endfunction
    function automatic logic [1:0] lv(input int i);
        int o;
        o = (i == 2 || i == 6) ? 4 : 2;
        return {rg[o+1][EB[i]], rg[o][EB[i]]};
    endfunction
    // strict compare keeps the lowest rank among equal levels
    function automatic int win(input logic [7:0] f, input int top);
        int b;
        int bl;
        b = -1;
        bl = top;
        for (int i = 0; i < 8; i++) begin
            if (f[i] && en(i) && int'(lv(i)) > bl) begin
                b = i;
                bl = int'(lv(i));
            end
        end
        return b;
    endfunction
    task automatic give_verdict;
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // waits for hready at a rising edge, bounded
    task automatic rdy;
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                give_verdict();
            end
            @(posedge clock);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
        `CHK("resp", 1'b0, hresp)
    endtask
    task automatic wait_call(output int n);
        n = 0;
        @(negedge clock);
        while (call.req !== 1'b1 && n < 80) begin
            @(negedge clock);
            n++;
        end
    endtask
    initial begin
        logic [31:0] q;
        logic [7:0]  f, pe;
        logic [1:0]  ed;
        logic        a0, a1;
        int          w, n, lvl;
        void'($urandom(32'h1d5c));
        repeat (40) begin
            @(posedge clock);
            rst <= 1'b1;
            // idle pins, so no stale level flag calls during setup
            p0 <= 1'b1;
            p1 <= 1'b1;
            repeat (2) @(posedge clock);
            rst <= 1'b0;
            for (int k = 0; k < 6; k++) begin
                rg[k] = 8'($urandom) & MSK[k];
                if (k == 0) rg[0][7] = ($urandom_range(3) != 0);
                bus(1'b0, 8'(4 * k), 32'h0, q);
                `CHK("reset", 32'h0, q)
                bus(1'b1, 8'(4 * k), {24'h0, rg[k]}, q);
                bus(1'b0, 8'(4 * k), 32'h0, q);
                `CHK("reg", {24'h0, rg[k]}, q)
            end
            bus(1'b0, 8'h40, 32'h0, q);
            `CHK("unmapped", 32'h0, q)
            ed = 2'($urandom);
            bus(1'b1, A_CTRL, {30'h0, ed}, q);
            // pins and set pulses land at the same sampling phase
            f = 8'($urandom) & 8'hde;
            a0 = 1'($urandom);
            a1 = 1'($urandom);
            p0 <= a0;
            p1 <= a1;
            src_set <= f;
            @(posedge clock);
            src_set <= 8'h0;
            f[0] = !a0;
            f[5] = !a1;
            lvl = -1;
            for (int k = 0; k < 2; k++) begin
                w = win(f, lvl);
                wait_call(n);
                `CHK("call", w >= 0, n < 80)
                if (w < 0) break;
                `CHK("vector", VT[w], call.vector)
                `CHK("level", lv(w), call.level)
                `CHK("phase", 2'h1, mc_phase)
                if (w == 3 || w == 7 || (w == 0 && ed[0])
                    || (w == 5 && ed[1])) begin
                    f[w] = 1'b0;
                end
                if (k == 0) begin
                    `CHK("latency", 1'b1, n < MAX_LAT_CLK)
                    lvl = int'(lv(w));
                    wait_call(n);
                    `CHK("hold", 1'b0, n < 80)
                    @(posedge clock);
                    bus(1'b0, A_STATUS, 32'h0, q);
                    `CHK("status", {VT[w], 16'h0} | 32'h10 | 32'(lv(w)),
                        q & 32'hffff007b)
                    return_from_interrupt_cmd <= 1'b1;
                    @(posedge clock);
                    return_from_interrupt_cmd <= 1'b0;
                    lvl = -1;
                end
            end
            // wake from the flags still pending, per power mode
            pm <= 3'($urandom);
            repeat (2) @(negedge clock);
            for (int i = 0; i < 8; i++) pe[i] = f[i] & en(i);
            if (pm[1]) begin
                pe = pe & (PD_WAKE | (pm[0] ? RC_WAKE : 8'h00));
            end else begin
                pe = pe & {8{pm[2]}};
            end
            `CHK("wake", |pe, wake)
            pm <= 3'h0;
        end
        give_verdict();
    end
endmodule
`default_nettype wire
